// [pkg/css_defines.svh]
// Constants for the command source selector
`ifndef CSS_DEFINES_SVH
`define CSS_DEFINES_SVH
`define CSS_SEL_W 14
`define CSS_REM_OPTION 14'h0000
`define CSS_REM_FRONT 14'h0002
`define CSS_SEL_AUTO 14'h270f
`define CSS_LOC_FRONT 14'h0002
`define CSS_LOC_USB 14'h0003
`define CSS_LOC_PANEL 14'h0004
`define CSS_REM_RESET 14'h270f
`define CSS_LOC_RESET 14'h270f
`define CSS_ADDR_REM 4'h0
`define CSS_ADDR_LOC 4'h1
`define CSS_ADDR_CTRL 4'h2
`define CSS_ADDR_STAT 4'h3
`define CSS_ADDR_LATCH 4'h4
`endif

// [pkg/css_pkg.sv]
// Types for the command source selector
package css_pkg;
  // Ports that can own command rights
  typedef enum logic [2:0] {
    CSS_SRC_NONE = 3'h0,
    CSS_SRC_PANEL = 3'h1,
    CSS_SRC_PUNIT = 3'h3,
    CSS_SRC_FRONT485 = 3'h2,
    CSS_SRC_USB = 3'h6,
    CSS_SRC_OPTION = 3'h7
  } css_src_t;
  // Operating mode
  typedef enum logic [1:0] {
    CSS_MODE_LOCAL = 2'h0,
    CSS_MODE_REMOTE = 2'h1
  } css_mode_t;
  // Port index for request and grant vectors
  typedef enum logic [2:0] {
    CSS_P_PANEL = 3'h0,
    CSS_P_PUNIT = 3'h1,
    CSS_P_FRONT = 3'h2,
    CSS_P_USB = 3'h3,
    CSS_P_OPTION = 3'h4
  } css_port_t;
endpackage : css_pkg

// [design/css_resolve.sv]
// Combinational source resolution for one latched configuration
`timescale 1ns/1ps
`default_nettype none
`include "css_defines.svh"
module css_resolve
  import css_pkg::*;
(
  // Latched selectors
  input wire logic [13:0] rem_in,
  input wire logic [13:0] loc_in,
  // Attachment state
  input wire logic opt_fitted_in,
  input wire logic usb_conn_in,
  input wire logic punit_conn_in,
  // Results
  output css_src_t local_src_out,
  output css_src_t remote_src_out,
  output logic remote_allowed_out
);
  always_comb begin
    unique case (loc_in)
      `CSS_LOC_FRONT: local_src_out = punit_conn_in ? CSS_SRC_PUNIT : CSS_SRC_FRONT485;
      `CSS_LOC_USB: local_src_out = CSS_SRC_USB;
      `CSS_LOC_PANEL: local_src_out = CSS_SRC_PANEL;
      default: begin
        // Auto: front RS-485 is never picked here
        if (usb_conn_in) local_src_out = CSS_SRC_USB;
        else if (punit_conn_in) local_src_out = CSS_SRC_PUNIT;
        else local_src_out = CSS_SRC_PANEL;
      end
    endcase
    remote_allowed_out = 1'b1;
    unique case (rem_in)
      `CSS_REM_OPTION: begin
        remote_src_out = CSS_SRC_OPTION;
        remote_allowed_out = opt_fitted_in;
      end
      `CSS_REM_FRONT: begin
        remote_src_out = CSS_SRC_FRONT485;
        // Local owns the front connector when both pick it
        if (loc_in == `CSS_LOC_FRONT) begin
          remote_src_out = opt_fitted_in ? CSS_SRC_OPTION : CSS_SRC_NONE;
          remote_allowed_out = opt_fitted_in;
        end
      end
      default: begin
        if (opt_fitted_in) remote_src_out = CSS_SRC_OPTION;
        else if (loc_in != `CSS_LOC_FRONT) remote_src_out = CSS_SRC_FRONT485;
        else begin
          remote_src_out = CSS_SRC_NONE;
          remote_allowed_out = 1'b0;
        end
      end
    endcase
  end
endmodule : css_resolve
`default_nettype wire

// [design/css_selector.sv]
// Command source selector top
`timescale 1ns/1ps
`default_nettype none
`include "css_defines.svh"
module css_selector
  import css_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Register port
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  // Attachment pins
  input wire logic opt_fitted_in,
  input wire logic usb_conn_in,
  input wire logic punit_conn_in,
  // Mode requests from panel key or link
  input wire logic req_remote_in,
  input wire logic req_local_in,
  // Command requests per port: panel, punit, front, usb, option
  input wire logic [4:0] cmd_req_in,
  input wire logic [4:0] read_req_in,
  input wire logic modbus_in,
  // Results
  output logic [4:0] cmd_grant_out,
  output logic [4:0] cmd_reject_out,
  output logic [4:0] read_grant_out,
  output logic remote_mode_out,
  output logic remote_refused_out,
  output logic panel_led_local_out,
  output logic panel_led_remote_out,
  output logic [2:0] active_src_out
);
  typedef struct packed {
    logic [2:0] opt_s;
    logic [2:0] usb_s;
    logic [2:0] pu_s;
    logic opt_q;
    logic usb_q;
    logic pu_q;
    logic [13:0] rem_pend;
    logic [13:0] loc_pend;
    logic [13:0] rem_lat;
    logic [13:0] loc_lat;
    logic relatch;
    css_mode_t mode;
    logic refused;
    logic [4:0] grant;
    logic [4:0] reject;
    logic [4:0] rgrant;
    logic led_l;
    logic led_r;
    css_src_t active;
    logic [15:0] rdata;
  } css_state_t;

  css_state_t st;
  css_state_t next_st;
  css_src_t local_src;
  css_src_t remote_src;
  logic remote_allowed;

  // Resolution uses the latched copy so pending writes have no effect
  css_resolve u_resolve (
    .rem_in(st.rem_lat),
    .loc_in(st.loc_lat),
    .opt_fitted_in(st.opt_q),
    .usb_conn_in(st.usb_q),
    .punit_conn_in(st.pu_q),
    .local_src_out(local_src),
    .remote_src_out(remote_src),
    .remote_allowed_out(remote_allowed)
  );

  // Map a source to its port bit
  function automatic logic [4:0] css_port_bit(input css_src_t s);
    logic [4:0] b;
    b = 5'h00;
    unique case (s)
      CSS_SRC_PANEL: b[CSS_P_PANEL] = 1'b1;
      CSS_SRC_PUNIT: b[CSS_P_PUNIT] = 1'b1;
      CSS_SRC_FRONT485: b[CSS_P_FRONT] = 1'b1;
      CSS_SRC_USB: b[CSS_P_USB] = 1'b1;
      CSS_SRC_OPTION: b[CSS_P_OPTION] = 1'b1;
      default: b = 5'h00;
    endcase
    return b;
  endfunction : css_port_bit

  // Settled value once second and third stages agree
  function automatic logic css_settle(input logic [2:0] s, input logic q);
    return (s[1] == s[2]) ? s[2] : q;
  endfunction : css_settle

  css_src_t cur_src;
  logic [4:0] own;

  always_comb begin
    next_st = st;
    next_st.opt_s = {st.opt_s[1:0], opt_fitted_in};
    next_st.usb_s = {st.usb_s[1:0], usb_conn_in};
    next_st.pu_s = {st.pu_s[1:0], punit_conn_in};
    next_st.opt_q = css_settle(st.opt_s, st.opt_q);
    next_st.usb_q = css_settle(st.usb_s, st.usb_q);
    next_st.pu_q = css_settle(st.pu_s, st.pu_q);
    next_st.relatch = 1'b0;
    next_st.rdata = 16'h0000;
    cur_src = (st.mode == CSS_MODE_REMOTE) ? remote_src : local_src;
    own = css_port_bit(cur_src);
    // Selector writes land in pending copies only; a control write sets relatch from bit 0
    if (wr_in) begin
      unique case (addr_in)
        `CSS_ADDR_REM: next_st.rem_pend = wdata_in[13:0];
        `CSS_ADDR_LOC: next_st.loc_pend = wdata_in[13:0];
        `CSS_ADDR_CTRL: next_st.relatch = wdata_in[0];
        default: ;
      endcase
    end
    // Soft reset applies pending selectors and returns to local
    if (st.relatch) begin
      next_st.rem_lat = st.rem_pend;
      next_st.loc_lat = st.loc_pend;
      next_st.mode = CSS_MODE_LOCAL;
      next_st.refused = 1'b0;
    end else if (req_remote_in && st.mode == CSS_MODE_LOCAL) begin
      if (remote_allowed) next_st.mode = CSS_MODE_REMOTE;
      next_st.refused = !remote_allowed;
    end else if (req_local_in) begin
      next_st.mode = CSS_MODE_LOCAL;
      next_st.refused = 1'b0;
    end
    // One owner only; Modbus is refused in local mode
    next_st.grant = cmd_req_in & own;
    if (modbus_in && st.mode == CSS_MODE_LOCAL)
      next_st.grant[CSS_P_FRONT] = 1'b0;
    next_st.reject = cmd_req_in & ~next_st.grant;
    next_st.rgrant = read_req_in;
    next_st.active = cur_src;
    // Indicators dark unless the panel owns commands
    next_st.led_l = (cur_src == CSS_SRC_PANEL) && (st.mode == CSS_MODE_LOCAL);
    next_st.led_r = (cur_src == CSS_SRC_PANEL) && (st.mode == CSS_MODE_REMOTE);
    if (rd_in) begin
      unique case (addr_in)
        `CSS_ADDR_REM: next_st.rdata = {2'h0, st.rem_pend};
        `CSS_ADDR_LOC: next_st.rdata = {2'h0, st.loc_pend};
        `CSS_ADDR_STAT: next_st.rdata = {8'h00, st.opt_q, st.refused,
                                          st.mode == CSS_MODE_REMOTE, 2'h0, cur_src};
        `CSS_ADDR_LATCH: next_st.rdata = {st.loc_lat[7:0], st.rem_lat[7:0]};
        default: next_st.rdata = 16'h0000;
      endcase
    end
  end

  // Power-on loads the default selectors straight into the latched copy
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st <= '0;
      st.rem_pend <= `CSS_REM_RESET;
      st.loc_pend <= `CSS_LOC_RESET;
      st.rem_lat <= `CSS_REM_RESET;
      st.loc_lat <= `CSS_LOC_RESET;
      st.mode <= CSS_MODE_LOCAL;
      st.active <= CSS_SRC_NONE;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_out = st.rdata;
  assign cmd_grant_out = st.grant;
  assign cmd_reject_out = st.reject;
  assign read_grant_out = st.rgrant;
  // Local and remote differ only in the low bit, so the output is a plain flop bit
  assign remote_mode_out = st.mode[0];
  assign remote_refused_out = st.refused;
  assign panel_led_local_out = st.led_l;
  assign panel_led_remote_out = st.led_r;
  assign active_src_out = st.active;
endmodule : css_selector
`default_nettype wire

// [sim/css_sel_sva.sv]
// Port assertions for the command source selector
`timescale 1ns/1ps
`default_nettype none
module css_sel_sva (
  // Watched ports
  input wire logic clk_in, nrst_in, req_remote_in, modbus_in, remote_mode_out,
  input wire logic remote_refused_out, panel_led_local_out, panel_led_remote_out,
  input wire logic [4:0] cmd_req_in, read_req_in, cmd_grant_out, cmd_reject_out, read_grant_out,
  input wire logic [2:0] active_src_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  chk_one_owner: assert property ($onehot0(cmd_grant_out))
    else $error("two owners");
  chk_grant_reject: assert property ((cmd_grant_out & cmd_reject_out) == 5'h0)
    else $error("grant and reject together");
  chk_answer_asked: assert property (((cmd_grant_out | cmd_reject_out) & ~$past(cmd_req_in)) == 5'h0)
    else $error("answer without request");
  chk_reads_served: assert property (read_grant_out == $past(read_req_in))
    else $error("read not served");
  chk_led_dark: assert property (active_src_out != 3'h1 |-> !(panel_led_local_out || panel_led_remote_out))
    else $error("indicator lit");
  chk_modbus_local: assert property (modbus_in && cmd_req_in[2] && !remote_mode_out |=> !cmd_grant_out[2])
    else $error("modbus granted in local");
  chk_refuse_cause: assert property ($rose(remote_refused_out) |-> $past(req_remote_in) && !remote_mode_out)
    else $error("refusal without request");
  chk_remote_cause: assert property ($rose(remote_mode_out) |-> $past(req_remote_in))
    else $error("remote without request");
  chk_refused_local: assert property (remote_refused_out |-> !remote_mode_out)
    else $error("refused while remote");
endmodule : css_sel_sva
`default_nettype wire

// [sim/css_far_ports.sv]
// Far-side ports model: panel, parameter unit, front link, USB host, option master
`timescale 1ns/1ps
`default_nettype none
module css_far_ports (
  // Clock
  input wire logic clk_in,
  // Requests toward the selector
  output logic [4:0] cmd_req_out, read_req_out,
  output logic modbus_out
);
  initial {cmd_req_out, read_req_out, modbus_out} = 11'h0;
  // One-cycle burst; Modbus flag goes out with the whole burst, whatever ports request
  task automatic send(input logic [4:0] c, input logic [4:0] r, input logic mb);
    @(posedge clk_in);
    {cmd_req_out, read_req_out, modbus_out} <= {c, r, mb};
    @(posedge clk_in);
    {cmd_req_out, read_req_out, modbus_out} <= 11'h0;
  endtask : send
endmodule : css_far_ports
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the command source selector
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_in = 0, nrst_in = 0, wr_in = 0, rd_in = 0, req_remote_in = 0, req_local_in = 0;
  logic opt_fitted_in = 0, usb_conn_in = 0, punit_conn_in = 0, modbus_in, remote_mode_out;
  logic remote_refused_out, panel_led_local_out, panel_led_remote_out;
  logic [3:0] addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0, rdata_out;
  logic [4:0] cmd_req_in, read_req_in, cmd_grant_out, cmd_reject_out, read_grant_out;
  logic [2:0] active_src_out;
  int errors = 0, cmp_count = 0;
  css_selector css_selector_inst (.*);
  css_far_ports css_far_ports_inst (.clk_in, .cmd_req_out(cmd_req_in),
    .read_req_out(read_req_in), .modbus_out(modbus_in));
  always #25 clk_in = ~clk_in;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Read data stand only in the cycle after the strobe
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    {addr_in, wdata_in, wr_in, rd_in} <= {a, d, w, !w};
    @(posedge clk_in);
    {wr_in, rd_in} <= 2'b0;
    #1 if (!w) chk(rdata_out, d);
  endtask : bus
  // Pins settle first, since detection may be taken at apply time
  task automatic cfg(input logic [15:0] r, input logic [15:0] l, input logic [2:0] pv);
    {opt_fitted_in, usb_conn_in, punit_conn_in} <= pv;
    repeat (8) @(posedge clk_in);
    bus(1'b1, 4'h0, r);
    bus(1'b1, 4'h1, l);
    bus(1'b1, 4'h2, 16'h1);
    repeat (2) @(posedge clk_in);
  endtask : cfg
  task automatic cmd(input logic [4:0] c, input logic mb, input logic [4:0] g);
    css_far_ports_inst.send(c, c, mb);
    #1 chk(16'(cmd_grant_out), 16'(g));
    chk(16'(read_grant_out), 16'(c));
    chk(16'(cmd_reject_out), 16'(c & ~g));
  endtask : cmd
  task automatic mode(input logic r, input logic e);
    @(posedge clk_in);
    {req_remote_in, req_local_in} <= {r, !r};
    @(posedge clk_in);
    {req_remote_in, req_local_in} <= 2'b0;
    #1 chk(16'(remote_mode_out), 16'(e));
  endtask : mode
  task automatic t_latch;
    bus(1'b0, 4'h0, 16'h270f);
    bus(1'b0, 4'h5, 16'h0);
    cfg(16'h270f, 16'h270f, 3'b010);
    bus(1'b1, 4'h1, 16'h4);
    bus(1'b0, 4'h1, 16'h4);
    cmd(5'h1f, 1'b0, 5'h08);
  endtask : t_latch
  task automatic t_local;
    cfg(16'h270f, 16'h3, 3'b000);
    cmd(5'h1f, 1'b0, 5'h08);
    chk(16'(active_src_out), 16'h6);
    chk(16'(panel_led_local_out), 16'h0);
    cfg(16'h270f, 16'h4, 3'b000);
    cmd(5'h1f, 1'b0, 5'h01);
    cfg(16'h270f, 16'h2, 3'b000);
    cmd(5'h1f, 1'b0, 5'h04);
    cmd(5'h04, 1'b1, 5'h00);
    mode(1'b1, 1'b0);
  endtask : t_local
  task automatic t_auto;
    cfg(16'h270f, 16'h270f, 3'b011);
    cmd(5'h1f, 1'b0, 5'h08);
    cfg(16'h270f, 16'h270f, 3'b001);
    cmd(5'h1f, 1'b0, 5'h02);
    cfg(16'h270f, 16'h270f, 3'b000);
    cmd(5'h1f, 1'b0, 5'h01);
    chk(16'(panel_led_local_out), 16'h1);
  endtask : t_auto
  task automatic t_remote;
    cfg(16'h270f, 16'h270f, 3'b000);
    mode(1'b1, 1'b1);
    cmd(5'h1f, 1'b1, 5'h04);
    cfg(16'h2, 16'h2, 3'b000);
    mode(1'b1, 1'b0);
    chk(16'(remote_refused_out), 16'h1);
    cfg(16'h0, 16'h270f, 3'b000);
    mode(1'b1, 1'b0);
    cfg(16'h0, 16'h270f, 3'b100);
    mode(1'b1, 1'b1);
    cmd(5'h1f, 1'b0, 5'h10);
    chk(16'(active_src_out), 16'h7);
    chk(16'(panel_led_remote_out), 16'h0);
    bus(1'b0, 4'h3, 16'h00a7);
    bus(1'b0, 4'h4, 16'h0f00);
    cfg(16'h2, 16'h4, 3'b100);
    mode(1'b1, 1'b1);
    cmd(5'h1f, 1'b0, 5'h04);
    cfg(16'h270f, 16'h270f, 3'b100);
    mode(1'b1, 1'b1);
    cmd(5'h1f, 1'b0, 5'h10);
    bus(1'b0, 4'h4, 16'h0f0f);
  endtask : t_remote
  task automatic report_and_stop;
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_latch;
    t_local;
    t_auto;
    t_remote;
    report_and_stop;
  end
  // Run is a few hundred cycles; the margin is wide
  initial begin
    #200000;
    errors++;
    report_and_stop;
  end
endmodule : tb
bind css_selector css_sel_sva css_sel_sva_inst (.*);
`default_nettype wire
